// File: logic/psr_snoop_ctrl.sv
/*
  psr_snoop_ctrl: classifies each parsed frame and decides plain layer-2
  forwarding, forwarding plus cpu copy, or trap to cpu only; holds the
  control and revision registers behind an axi4-lite slave.
  assumes: one descriptor per frame_valid pulse, synchronous to clock;
  verdict follows one cycle later on verdict_valid.
*/
// Functional notes
// R01: listener query mode: trap, else forward+copy
// R02: listener query handled only when enabled
// R03: listener report/done mode: trap, else forward+copy
// R04: listener report/done handled only when enabled
// R05: unknown group message mode: trap, else forward+copy
// R06: unknown group message handled only when enabled
// R07: group query mode: trap, else forward+copy
// R08: group query handled only when enabled
// R09: group report/leave mode: trap, else forward+copy
// R10: group report/leave handled only when enabled
// R11: optional class d destination classifies group
// R12: v6 ctrl mode: trap, else forward+copy
// R13: next header 58 is v6 ctrl
// R14: next header 0 then 58 too
// R15: v4 ctrl snoop adds cpu copy
// R16: host config snoop adds cpu copy
// R17: reverse resolve snoop adds cpu copy
// R18: address resolve snoop adds cpu copy
// R19: mode bit ignored while enable is clear
// R20: control bits reset to zero
`timescale 1ns/1ps

module psr_snoop_ctrl #(
  parameter int CPU_PORT = 8,
  parameter logic [7:0] REVISION = psr_pkg::SILICON_REVISION_DEFAULT
) (
  input wire logic clock,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frame path
  input wire logic frame_valid,
  input wire psr_pkg::psr_frame_s frame,
  output logic verdict_valid,
  output psr_pkg::psr_verdict_s verdict
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [31:0] ctrl;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic vvalid;
    psr_pkg::psr_verdict_s verdict;
  } psr_state_s;

  psr_state_s state_reg;
  psr_state_s state_next;

  // ==========================================================================
  // classification
  // ==========================================================================
  logic [31:0] c;
  logic is_group;
  logic is_v6_ctrl;
  logic snoop;
  logic trap;

  assign c = state_reg.ctrl;

  always_comb begin
    is_group = frame.is_ipv4 &&
      ((frame.ipv4_protocol == psr_pkg::IP_PROTO_GROUP_MGMT) ||
       (c[psr_pkg::GROUP_DEST_ADDR_CHECK_ENABLE_BIT] &&
        frame.destination_ip_address[31:28] == psr_pkg::CLASS_D_PREFIX)); // R11
    is_v6_ctrl = frame.is_ipv6 &&
      ((frame.ipv6_next_header == psr_pkg::V6_NEXT_HDR_CTRL_MSG) || // R13
       (frame.ipv6_next_header == psr_pkg::V6_NEXT_HDR_HOP_BY_HOP &&
        frame.ext_next_header == psr_pkg::V6_NEXT_HDR_CTRL_MSG)); // R14
    snoop = 1'b0;
    trap = 1'b0;
    // trap only ever qualified by the class enable
    if (is_v6_ctrl) begin
      unique case (frame.v6_kind)
        psr_pkg::PSR_V6_LISTENER_QUERY: begin
          snoop = c[psr_pkg::LISTENER_QUERY_SNOOP_ENABLE_BIT]; // R02
          trap = snoop && c[psr_pkg::LISTENER_QUERY_TRAP_MODE_BIT]; // R01 R19
        end
        psr_pkg::PSR_V6_LISTENER_REPORT: begin
          snoop = c[psr_pkg::LISTENER_REPORT_SNOOP_ENABLE_BIT]; // R04
          trap = snoop && c[psr_pkg::LISTENER_REPORT_TRAP_MODE_BIT]; // R03 R19
        end
        psr_pkg::PSR_V6_OTHER: begin
          snoop = c[psr_pkg::CTRL_MSG_V6_SNOOP_ENABLE_BIT]; // R12
          trap = snoop && c[psr_pkg::CTRL_MSG_V6_TRAP_MODE_BIT]; // R12 R19
        end
        default: begin
          snoop = 1'b0;
          trap = 1'b0;
        end
      endcase
    end else if (is_group) begin
      unique case (frame.grp_kind)
        psr_pkg::PSR_GRP_QUERY: begin
          snoop = c[psr_pkg::GROUP_QUERY_SNOOP_ENABLE_BIT]; // R08
          trap = snoop && c[psr_pkg::GROUP_QUERY_TRAP_MODE_BIT]; // R07 R19
        end
        psr_pkg::PSR_GRP_REPORT: begin
          snoop = c[psr_pkg::GROUP_REPORT_SNOOP_ENABLE_BIT]; // R10
          trap = snoop && c[psr_pkg::GROUP_REPORT_TRAP_MODE_BIT]; // R09 R19
        end
        psr_pkg::PSR_GRP_UNKNOWN: begin
          snoop = c[psr_pkg::GROUP_UNKNOWN_SNOOP_ENABLE_BIT]; // R06
          trap = snoop && c[psr_pkg::GROUP_UNKNOWN_TRAP_MODE_BIT]; // R05 R19
        end
        default: begin
          snoop = 1'b0;
          trap = 1'b0;
        end
      endcase
    end else if (frame.is_ctrl_msg_v4) begin
      snoop = c[psr_pkg::CTRL_MSG_V4_SNOOP_ENABLE_BIT]; // R15
    end else if (frame.is_host_config) begin
      snoop = c[psr_pkg::HOST_CONFIG_SNOOP_ENABLE_BIT]; // R16
    end else if (frame.is_reverse_resolve) begin
      snoop = c[psr_pkg::REVERSE_RESOLVE_SNOOP_ENABLE_BIT]; // R17
    end else if (frame.is_addr_resolve) begin
      snoop = c[psr_pkg::ADDR_RESOLVE_SNOOP_ENABLE_BIT]; // R18
    end
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  logic do_write;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [8:0] cpu_bit;

  assign cpu_bit = 9'h001 << CPU_PORT;

  always_comb begin
    state_next = state_reg;
    wa = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr;
    wd = state_reg.w_held ? state_reg.w_data : s_axi_wdata;
    ws = state_reg.w_held ? state_reg.w_strb : s_axi_wstrb;
    // address and data may come in either order; hold whichever arrives first
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    do_write = !state_reg.bvalid &&
      (state_reg.aw_held || s_axi_awvalid) && (state_reg.w_held || s_axi_wvalid);
    if (do_write) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = psr_pkg::AXI_RESP_OKAY;
      if (wa[7:2] == psr_pkg::PROTOCOL_SNOOP_CONTROL_OFFSET[7:2]) begin
        for (int i = 0; i < 4; i++) begin
          if (ws[i]) begin
            state_next.ctrl[8*i +: 8] = wd[8*i +: 8];
          end
        end
      end else if (wa[7:2] != psr_pkg::SILICON_REVISION_OFFSET[7:2]) begin
        state_next.bresp = psr_pkg::AXI_RESP_SLVERR;
      end
    end else if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = psr_pkg::AXI_RESP_OKAY;
      if (s_axi_araddr[7:2] == psr_pkg::PROTOCOL_SNOOP_CONTROL_OFFSET[7:2]) begin
        state_next.rdata = state_reg.ctrl;
      end else if (s_axi_araddr[7:2] == psr_pkg::SILICON_REVISION_OFFSET[7:2]) begin
        state_next.rdata = {24'h000000, REVISION};
      end else begin
        state_next.rdata = 32'h0000_0000;
        state_next.rresp = psr_pkg::AXI_RESP_SLVERR;
      end
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // verdict, one cycle after the descriptor
    state_next.vvalid = frame_valid;
    if (frame_valid) begin
      state_next.verdict.trapped = trap;
      state_next.verdict.copy_to_cpu = snoop;
      state_next.verdict.port_mask = trap ? cpu_bit :
        (snoop ? (frame.l2_port_mask | cpu_bit) : frame.l2_port_mask);
    end

    // ready flags kept in flops so the bus outputs carry no logic
    state_next.awrdy = !state_next.aw_held && !state_next.bvalid;
    state_next.wrdy = !state_next.w_held && !state_next.bvalid;
    state_next.arrdy = !state_next.rvalid;

    if (sys_rst) begin
      state_next = '0;
      state_next.ctrl = psr_pkg::PROTOCOL_SNOOP_CONTROL_RESET; // R20
    end
  end

  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready = state_reg.awrdy;
  assign s_axi_wready = state_reg.wrdy;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arrdy;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign verdict_valid = state_reg.vvalid;
  assign verdict = state_reg.verdict;

  // ==========================================================================
  // checks
  // ==========================================================================
  a_reset_ctrl_zero: assert property (@(posedge clock) // R20
    sys_rst |=> state_reg.ctrl == 32'h0000_0000)
    else $error("control not cleared by reset");

  a_trap_needs_enable: assert property (@(posedge clock) disable iff (sys_rst) // R19
    verdict_valid && verdict.trapped |-> verdict.copy_to_cpu)
    else $error("trap without enable");

  a_trap_cpu_only: assert property (@(posedge clock) disable iff (sys_rst) // R01
    verdict_valid && verdict.trapped |-> verdict.port_mask == cpu_bit)
    else $error("trapped frame not cpu only");

  a_copy_keeps_l2: assert property (@(posedge clock) disable iff (sys_rst) // R15
    frame_valid && !trap && snoop |=>
      verdict.port_mask == ($past(frame.l2_port_mask) | cpu_bit))
    else $error("copy lost layer-2 ports");

  a_plain_l2_path: assert property (@(posedge clock) disable iff (sys_rst) // R18
    frame_valid && !snoop |=> verdict_valid && !verdict.copy_to_cpu &&
      verdict.port_mask == $past(frame.l2_port_mask))
    else $error("plain frame altered");

  a_arp_snoop: assert property (@(posedge clock) disable iff (sys_rst) // R18
    frame_valid && frame.is_addr_resolve && !frame.is_ipv4 && !frame.is_ipv6 &&
      !frame.is_ctrl_msg_v4 && !frame.is_host_config && !frame.is_reverse_resolve |=>
      verdict.copy_to_cpu == $past(c[psr_pkg::ADDR_RESOLVE_SNOOP_ENABLE_BIT]))
    else $error("resolve snoop mismatch");

  a_group_query: assert property (@(posedge clock) disable iff (sys_rst) // R07
    frame_valid && frame.is_ipv4 && !frame.is_ipv6 &&
      frame.ipv4_protocol == psr_pkg::IP_PROTO_GROUP_MGMT &&
      frame.grp_kind == psr_pkg::PSR_GRP_QUERY |=>
      verdict.trapped == $past(c[psr_pkg::GROUP_QUERY_TRAP_MODE_BIT] &&
        c[psr_pkg::GROUP_QUERY_SNOOP_ENABLE_BIT]))
    else $error("group query verdict wrong");

  a_v6_ext_hdr: assert property (@(posedge clock) disable iff (sys_rst) // R14
    frame_valid && frame.is_ipv6 && frame.ipv6_next_header == psr_pkg::V6_NEXT_HDR_HOP_BY_HOP &&
      frame.ext_next_header == psr_pkg::V6_NEXT_HDR_CTRL_MSG &&
      frame.v6_kind == psr_pkg::PSR_V6_OTHER |=>
      verdict.copy_to_cpu == $past(c[psr_pkg::CTRL_MSG_V6_SNOOP_ENABLE_BIT]))
    else $error("v6 extension header missed");

  a_write_resp: assert property (@(posedge clock) disable iff (sys_rst)
    do_write |=> s_axi_bvalid)
    else $error("write not answered");

  a_read_resp: assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");

endmodule : psr_snoop_ctrl

// File: logic/psr_pkg.sv
/*
  psr_pkg: register map, field positions, reset values and the frame
  descriptor carriers for the protocol snoop/redirect control block.
  assumes: a switch ingress parser fills the descriptor fields.
*/
package psr_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] SILICON_REVISION_OFFSET = 8'h40;
  localparam logic [7:0] PROTOCOL_SNOOP_CONTROL_OFFSET = 8'h50;
  localparam logic [31:0] PROTOCOL_SNOOP_CONTROL_RESET = 32'h0000_0000;
  // revision code value is arbitrary
  localparam logic [7:0] SILICON_REVISION_DEFAULT = 8'h5a;

  // ==========================================================================
  // control field positions
  // ==========================================================================
  localparam int LISTENER_QUERY_TRAP_MODE_BIT = 18;
  localparam int LISTENER_QUERY_SNOOP_ENABLE_BIT = 17;
  localparam int LISTENER_REPORT_TRAP_MODE_BIT = 16;
  localparam int LISTENER_REPORT_SNOOP_ENABLE_BIT = 15;
  localparam int GROUP_UNKNOWN_TRAP_MODE_BIT = 14;
  localparam int GROUP_UNKNOWN_SNOOP_ENABLE_BIT = 13;
  localparam int GROUP_QUERY_TRAP_MODE_BIT = 12;
  localparam int GROUP_QUERY_SNOOP_ENABLE_BIT = 11;
  localparam int GROUP_REPORT_TRAP_MODE_BIT = 10;
  localparam int GROUP_REPORT_SNOOP_ENABLE_BIT = 9;
  localparam int GROUP_DEST_ADDR_CHECK_ENABLE_BIT = 8;
  localparam int CTRL_MSG_V6_TRAP_MODE_BIT = 5;
  localparam int CTRL_MSG_V6_SNOOP_ENABLE_BIT = 4;
  localparam int CTRL_MSG_V4_SNOOP_ENABLE_BIT = 3;
  localparam int HOST_CONFIG_SNOOP_ENABLE_BIT = 2;
  localparam int REVERSE_RESOLVE_SNOOP_ENABLE_BIT = 1;
  localparam int ADDR_RESOLVE_SNOOP_ENABLE_BIT = 0;

  // ==========================================================================
  // protocol constants
  // ==========================================================================
  localparam logic [7:0] IP_PROTO_GROUP_MGMT = 8'h02;
  localparam logic [7:0] V6_NEXT_HDR_CTRL_MSG = 8'h3a;
  localparam logic [7:0] V6_NEXT_HDR_HOP_BY_HOP = 8'h00;
  localparam logic [3:0] CLASS_D_PREFIX = 4'he;
  localparam logic [1:0] AXI_RESP_OKAY = 2'b00;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'b10;

  // group-management message type, decoded by the parser
  typedef enum logic [1:0] {
    PSR_GRP_QUERY,
    PSR_GRP_REPORT,
    PSR_GRP_UNKNOWN
  } psr_grp_kind_e;

  // listener message kind within ctrl messages v6
  typedef enum logic [1:0] {
    PSR_V6_OTHER,
    PSR_V6_LISTENER_QUERY,
    PSR_V6_LISTENER_REPORT
  } psr_v6_kind_e;

  // per-frame descriptor from the ingress parser
  typedef struct packed {
    logic is_ipv4;
    logic [7:0] ipv4_protocol;
    logic [31:0] destination_ip_address;
    psr_grp_kind_e grp_kind;
    logic is_ipv6;
    logic [7:0] ipv6_next_header;
    logic [7:0] ext_next_header;
    psr_v6_kind_e v6_kind;
    logic is_ctrl_msg_v4;
    logic is_host_config;
    logic is_reverse_resolve;
    logic is_addr_resolve;
    logic [8:0] l2_port_mask;
  } psr_frame_s;

  // verdict to the forwarding logic
  typedef struct packed {
    logic [8:0] port_mask;
    logic copy_to_cpu;
    logic trapped;
  } psr_verdict_s;

endpackage : psr_pkg

// File: tb/psr_parser_model.sv
/*
  psr_parser_model: stands in for the switch ingress parser, turning a
  small frame kind code into one descriptor pulse for the snoop block.
  assumes: send is a one-cycle request, driven just after a clock edge.
*/
`timescale 1ns/1ps

module psr_parser_model (
  input wire logic clock,
  input wire logic send,
  input wire logic [3:0] kind,
  input wire logic [8:0] l2_mask,
  output logic frame_valid,
  output psr_pkg::psr_frame_s frame
);
  // ==========================================================================
  // descriptor builder
  // ==========================================================================
  function automatic psr_pkg::psr_frame_s build(input logic [3:0] k, input logic [8:0] m);
    psr_pkg::psr_frame_s f;
    f = '0;
    f.l2_port_mask = m;
    case (k)
      4'h0, 4'h1, 4'h2: begin
        f.is_ipv4 = 1'b1;
        f.ipv4_protocol = psr_pkg::IP_PROTO_GROUP_MGMT;
        f.grp_kind = psr_pkg::psr_grp_kind_e'(k[1:0]);
      end
      // group only through a class d destination
      4'h3: begin
        f.is_ipv4 = 1'b1;
        f.ipv4_protocol = 8'h11;
        f.destination_ip_address = 32'he000_00fb;
      end
      4'h4, 4'h5, 4'h6: begin
        f.is_ipv6 = 1'b1;
        f.ipv6_next_header = psr_pkg::V6_NEXT_HDR_CTRL_MSG;
        f.v6_kind = psr_pkg::psr_v6_kind_e'(k == 4'h4 ? 2'h1 : k == 4'h5 ? 2'h2 : 2'h0);
      end
      4'h7: begin
        f.is_ipv6 = 1'b1;
        f.ext_next_header = psr_pkg::V6_NEXT_HDR_CTRL_MSG;
      end
      4'h8: begin
        f.is_ipv4 = 1'b1;
        f.ipv4_protocol = 8'h01;
        f.is_ctrl_msg_v4 = 1'b1;
      end
      4'h9: f.is_host_config = 1'b1;
      4'ha: f.is_reverse_resolve = 1'b1;
      4'hb: f.is_addr_resolve = 1'b1;
      default: begin
        f.is_ipv4 = 1'b1;
        f.ipv4_protocol = 8'h06;
      end
    endcase
    return f;
  endfunction : build

  // descriptor lines toggle between frames so no stale value looks valid
  initial frame = '0;
  always @(posedge clock) begin
    frame_valid <= send;
    frame <= send ? build(kind, l2_mask) : ~frame;
  end
endmodule : psr_parser_model

// File: tb/testbench.sv
/*
  testbench: register and frame verdict checks for psr_snoop_ctrl.
  assumes: 125 MHz clock, synchronous active-high reset, cpu port 8.
*/
`timescale 1ns/1ps

module testbench;
  logic clock = 0;
  logic sys_rst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic send = 0;
  logic [3:0] kind = 0;
  logic frame_valid, verdict_valid;
  psr_pkg::psr_frame_s frame;
  psr_pkg::psr_verdict_s verdict;
  int mismatches = 0;
  int checks_done = 0;
  int en_b[13] = '{11, 9, 13, 11, 17, 15, 4, 4, 3, 2, 1, 0, -1};
  int md_b[13] = '{12, 10, 14, 12, 18, 16, 5, 5, -1, -1, -1, -1, -1};

  psr_snoop_ctrl psr_snoop_ctrl_i (.clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_valid(frame_valid),
    .frame(frame), .verdict_valid(verdict_valid), .verdict(verdict));
  psr_parser_model psr_parser_model_i (.clock(clock), .send(send), .kind(kind),
    .l2_mask(9'h015), .frame_valid(frame_valid), .frame(frame));

  // ==========================================================================
  // clock, watchdog and verdict
  // ==========================================================================
  initial begin
    forever #4 clock = ~clock;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    wrap_up();
  end

  // ==========================================================================
  // access tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                           output logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    // one idle edge so a following call never reassigns bready in this step
    @(posedge clock);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clock);
  endtask : axi_read

  // verdict pulse must last exactly one cycle
  task automatic send_frame(input logic [3:0] k);
    send <= 1;
    kind <= k;
    @(posedge clock);
    send <= 0;
    do @(posedge clock); while (verdict_valid !== 1'b1);
    @(posedge clock);
    chk({31'h0, verdict_valid}, 32'h0);
  endtask : send_frame

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    logic [31:0] d, c;
    logic [1:0] r;
    logic act, trp;
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    axi_read(8'h50, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h0);
    axi_read(8'h40, d, r);
    chk(d, {24'h0, psr_pkg::SILICON_REVISION_DEFAULT});
    $display("test reset_values done");
    // read-only place, byte lanes, unmapped place
    axi_write(8'h40, 32'hffff_ffff, 4'hf, r);
    chk({30'h0, r}, {30'h0, psr_pkg::AXI_RESP_OKAY});
    axi_read(8'h40, d, r);
    chk(d, {24'h0, psr_pkg::SILICON_REVISION_DEFAULT});
    axi_write(8'h50, 32'hffff_ffff, 4'hf, r);
    axi_write(8'h50, 32'h0, 4'h2, r);
    axi_read(8'h50, d, r);
    chk(d, 32'hffff_00ff);
    axi_write(8'h60, 32'h1, 4'hf, r);
    chk({30'h0, r}, {30'h0, psr_pkg::AXI_RESP_SLVERR});
    axi_read(8'h60, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, psr_pkg::AXI_RESP_SLVERR});
    $display("test register_access done");
    // each class: off, enable only, mode only, both, then both without bit 8
    for (int k = 0; k < 13; k++) begin
      for (int s = 0; s < 5; s++) begin
        c = 32'h0;
        if (en_b[k] < 0) c = 32'h0007_ff3f;
        else begin
          if (s[0] || s == 4) c[en_b[k]] = 1'b1;
          if (md_b[k] >= 0 && (s[1] || s == 4)) c[md_b[k]] = 1'b1;
          if (s < 4) c[8] = 1'b1;
        end
        act = en_b[k] >= 0 && (s[0] || s == 4) && !(k == 3 && s == 4);
        trp = act && md_b[k] >= 0 && (s[1] || s == 4);
        axi_write(8'h50, c, 4'hf, r);
        send_frame(4'(k));
        chk({23'h0, verdict.port_mask}, trp ? 32'h100 : act ? 32'h115 : 32'h015);
        chk({31'h0, verdict.trapped}, {31'h0, trp});
        if (!trp) chk({31'h0, verdict.copy_to_cpu}, {31'h0, act});
      end
    end
    $display("test frame_verdicts done");
    // reset in mid-run must clear a control word left nonzero
    sys_rst <= 1;
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    axi_read(8'h50, d, r);
    chk(d, 32'h0);
    $display("test midrun_reset done");
    wrap_up();
  end
endmodule : testbench
